// ---- hdl/tmm_top.sv ----
/*
  Table-read path and banked data memory of the small controller.
  Assumes program words return in the same cycle the address is presented,
  and that the core holds off new requests while o_stall is high.
*/
`timescale 1ns/1ps
`default_nettype none
module tmm_top
  import tmm_pkg::*;
#(
  parameter int unsigned GP_BYTES = 128,
  parameter int unsigned PWORD_BITS = 16
) (
  // Clock, reset, enable
  input wire logic i_clk_sys,
  input wire logic i_rstn,
  input wire logic i_ce,
  // Core data access
  input wire tmm_dreq_t i_dreq,
  output logic [7:0] o_rdata,
  output logic o_rvalid,
  // Core table read
  input wire tmm_treq_t i_treq,
  output logic o_stall,
  output logic o_tdone,
  // Program memory port
  output logic [10:0] o_paddr,
  output logic o_pread,
  input wire logic [15:0] i_pdata,
  // Serial programming line, three signals per two-way pin
  input wire logic i_prog_serial_data_line,
  output logic o_prog_serial_data_line,
  output logic o_prog_serial_data_line_oe,
  input wire logic i_prog_serial_clock_line,
  // Bank state for observers
  output logic o_bank
);
  // Register file: 2 banks x 128 upper bytes, flip-flops
  logic [7:0] mem_q [0:2*GP_BYTES-1];
  logic [7:0] mem_d [0:2*GP_BYTES-1];
  logic [7:0] low_ptr_q, low_ptr_d; // Table pointer low
  logic [7:0] high_ptr_q, high_ptr_d; // Table pointer high
  logic [7:0] tbl_hi_q, tbl_hi_d; // table_high_byte_latch
  logic [7:0] bank_select_pointer_q, bank_select_pointer_d;
  logic [7:0] rdata_q, rdata_d;
  logic rvalid_q, rvalid_d;
  tmm_state_t st_q, st_d;
  logic [7:0] dest_q, dest_d;
  logic [10:0] paddr_q, paddr_d;
  logic pread_q, pread_d;
  logic stall_q, stall_d;
  logic tdone_q, tdone_d;
  logic [15:0] pword;
  logic [7:0] wr_index;
  logic wr_en;
  logic [7:0] wr_val;

  // Mask away program word bits that have no storage behind them
  assign pword = i_pdata & 16'((32'h1 << PWORD_BITS) - 32'h1);

  // Sequencer and register next-state
  always_comb begin
    st_d = st_q;
    dest_d = dest_q;
    paddr_d = paddr_q;
    pread_d = 1'b0;
    stall_d = stall_q;
    tdone_d = 1'b0;
    low_ptr_d = low_ptr_q;
    high_ptr_d = high_ptr_q;
    tbl_hi_d = tbl_hi_q;
    bank_select_pointer_d = bank_select_pointer_q;
    rdata_d = rdata_q;
    rvalid_d = 1'b0;
    wr_en = 1'b0;
    wr_index = TMM_ZERO;
    wr_val = TMM_ZERO;
    unique case (st_q)
      TMM_IDLE: begin
        if (i_treq.go) begin
          // Address formed on the request; bus stalls the core meanwhile
          if (i_treq.last_page) begin
            paddr_d = TMM_LAST_PAGE | {3'b000, low_ptr_q};
          end else begin
            paddr_d = {high_ptr_q[2:0], low_ptr_q};
          end
          pread_d = 1'b1;
          stall_d = 1'b1;
          dest_d = i_treq.dest;
          st_d = TMM_FETCH;
        end else if (i_dreq.wr) begin
          unique case (i_dreq.addr)
            TMM_ADDR_LOW_PTR: low_ptr_d = i_dreq.wdata;
            TMM_ADDR_HIGH_PTR: high_ptr_d = i_dreq.wdata;
            TMM_ADDR_BANK_PTR: bank_select_pointer_d = i_dreq.wdata & TMM_BANK_MASK;
            TMM_ADDR_HIGH_BYTE: tbl_hi_d = tbl_hi_q;
            default: begin
              // Upper half goes to storage of the selected bank
              if (i_dreq.addr >= TMM_UPPER_BASE) begin
                wr_en = 1'b1;
                wr_index = {bank_select_pointer_q[0], i_dreq.addr[6:0]};
                wr_val = i_dreq.wdata;
              end
            end
          endcase
        end else if (i_dreq.rd) begin
          rvalid_d = 1'b1;
          unique case (i_dreq.addr)
            TMM_ADDR_LOW_PTR: rdata_d = low_ptr_q;
            TMM_ADDR_HIGH_PTR: rdata_d = high_ptr_q;
            TMM_ADDR_BANK_PTR: rdata_d = bank_select_pointer_q;
            TMM_ADDR_HIGH_BYTE: rdata_d = tbl_hi_q;
            default: begin
              if (i_dreq.addr >= TMM_UPPER_BASE) begin
                rdata_d = mem_q[{bank_select_pointer_q[0], i_dreq.addr[6:0]}];
              end else begin
                rdata_d = TMM_ZERO;
              end
            end
          endcase
        end
      end
      TMM_FETCH: begin
        // Program word arrives; high byte latched in hardware
        tbl_hi_d = pword[15:8];
        wr_val = pword[7:0];
        dest_d = dest_q;
        // Low byte is written in this first stalled cycle; the second cycle only releases the core
        st_d = TMM_WRITE;
        if (dest_q == TMM_ADDR_LOW_PTR) begin
          low_ptr_d = pword[7:0];
        end else if (dest_q == TMM_ADDR_HIGH_PTR) begin
          high_ptr_d = pword[7:0];
        end else if (dest_q == TMM_ADDR_BANK_PTR) begin
          bank_select_pointer_d = pword[7:0] & TMM_BANK_MASK;
        end else if (dest_q >= TMM_UPPER_BASE) begin
          wr_en = 1'b1;
          wr_index = {bank_select_pointer_q[0], dest_q[6:0]};
        end
      end
      TMM_WRITE: begin
        // Release the core after the two-cycle table instruction
        stall_d = 1'b0;
        tdone_d = 1'b1;
        st_d = TMM_IDLE;
      end
      default: st_d = TMM_IDLE;
    endcase
  end

  // Storage next-state, one entry per generate pass
  for (genvar g = 0; g < 2 * GP_BYTES; g++) begin : g_mem
    always_comb begin
      mem_d[g] = mem_q[g];
      if (wr_en && (wr_index == 8'(g))) begin
        mem_d[g] = wr_val;
      end
    end
    // Storage powers up cleared so reads are defined
    always_ff @(posedge i_clk_sys or negedge i_rstn) begin
      if (!i_rstn) begin
        mem_q[g] <= TMM_ZERO;
      end else if (i_ce) begin
        mem_q[g] <= mem_d[g];
      end
    end
  end

  // Control registers
  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      st_q <= TMM_IDLE;
      dest_q <= TMM_ZERO;
      paddr_q <= '0;
      pread_q <= 1'b0;
      stall_q <= 1'b0;
      tdone_q <= 1'b0;
      low_ptr_q <= TMM_ZERO;
      high_ptr_q <= TMM_ZERO;
      tbl_hi_q <= TMM_ZERO;
      bank_select_pointer_q <= TMM_ZERO;
      rdata_q <= TMM_ZERO;
      rvalid_q <= 1'b0;
    end else if (i_ce) begin
      st_q <= st_d;
      dest_q <= dest_d;
      paddr_q <= paddr_d;
      pread_q <= pread_d;
      stall_q <= stall_d;
      tdone_q <= tdone_d;
      low_ptr_q <= low_ptr_d;
      high_ptr_q <= high_ptr_d;
      tbl_hi_q <= tbl_hi_d;
      bank_select_pointer_q <= bank_select_pointer_d;
      rdata_q <= rdata_d;
      rvalid_q <= rvalid_d;
    end
  end

  // Programming protocol is not modelled; the line is released
  logic prog_dout_q;
  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      prog_dout_q <= 1'b0;
    end else if (i_ce) begin
      prog_dout_q <= 1'b0;
    end
  end

  assign o_rdata = rdata_q;
  assign o_rvalid = rvalid_q;
  assign o_stall = stall_q;
  assign o_tdone = tdone_q;
  assign o_paddr = paddr_q;
  assign o_pread = pread_q;
  assign o_prog_serial_data_line = prog_dout_q;
  assign o_prog_serial_data_line_oe = prog_dout_q;
  assign o_bank = bank_select_pointer_q[0];
endmodule
`default_nettype wire

// ---- hdl/tmm_pkg.sv ----
/*
  Constants and carrier types for the table-read and data memory map block.
  Assumes a single 100 MHz system clock and an instruction core that issues
  one access request per instruction cycle through the request struct.
*/
// Summary of operation
// - Full table read uses high:low pointer address
// - Last-page read uses 700H plus low pointer
// - Table read loads upper byte into latch
// - High byte latch ignores software writes
// - Table instructions take two instruction cycles
// - Programming uses serial data line plus clock (protocol not modelled; data line is released)
// - Data memory is two banks, 8-bit wide
// - 00H-7FH special registers, bank 0 80H-FFH general
// - Bank 1 upper half is two PWM buffers (code stores it as plain bytes like bank 0)
// - Bank pointer register selects accessed bank
// - Table read low byte goes to operand location
// - Unbacked high-byte bits read as zero
// - Unused special locations read as 00H
package tmm_pkg;
  localparam int unsigned TMM_PADDR_W = 11;
  localparam int unsigned TMM_PWORD_W = 16;
  localparam int unsigned TMM_PHI_W = 8;
  localparam logic [10:0] TMM_LAST_PAGE = 11'h700;
  localparam logic [7:0] TMM_UPPER_BASE = 8'h80;
  localparam logic [7:0] TMM_BUFB_BASE = 8'hC0;
  localparam logic [7:0] TMM_ZERO = 8'h00;
  localparam logic [7:0] TMM_ADDR_LOW_PTR = 8'h07;
  localparam logic [7:0] TMM_ADDR_HIGH_BYTE = 8'h08;
  localparam logic [7:0] TMM_ADDR_HIGH_PTR = 8'h09;
  localparam logic [7:0] TMM_ADDR_BANK_PTR = 8'h04;
  localparam logic [7:0] TMM_BANK_MASK = 8'h01;
  localparam logic [7:0] TMM_HIPTR_MASK = 8'h07;

  // One data memory access from the core
  typedef struct packed {
    logic rd;
    logic wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } tmm_dreq_t;

  // One table read request from the core
  typedef struct packed {
    logic go;
    logic last_page;
    logic [7:0] dest;
  } tmm_treq_t;

  typedef enum logic [1:0] {
    TMM_IDLE = 2'b00,
    TMM_FETCH = 2'b01,
    TMM_WRITE = 2'b10
  } tmm_state_t;
endpackage

// ---- verification/tmm_top_monitor.sv ----
/* Checker for the tmm_top ports.
   Assumes i_ce drops only while no table read is in flight. */
`timescale 1ns/1ps
`default_nettype none
module tmm_top_monitor
  import tmm_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic i_rstn,
  input wire logic i_ce,
  input wire tmm_dreq_t i_dreq,
  input wire logic [7:0] o_rdata,
  input wire logic o_rvalid,
  input wire tmm_treq_t i_treq,
  input wire logic o_stall,
  input wire logic o_tdone,
  input wire logic [10:0] o_paddr,
  input wire logic o_pread,
  input wire logic [15:0] i_pdata,
  input wire logic i_prog_serial_data_line,
  input wire logic o_prog_serial_data_line,
  input wire logic o_prog_serial_data_line_oe,
  input wire logic i_prog_serial_clock_line,
  input wire logic o_bank
);
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_rstn);
  // Idle excludes the done cycle, so a slow return to idle never misfires
  wire logic idle = i_ce && !o_stall && !o_tdone;
  wire logic go_t = idle && i_treq.go;
  wire logic rd_t = idle && !i_treq.go && i_dreq.rd && !i_dreq.wr;
  wire logic wr_t = idle && !i_treq.go && i_dreq.wr;
  wire logic spr = !i_dreq.addr[7] && !(i_dreq.addr inside {8'h04, 8'h07, 8'h08, 8'h09});
  AST_TBL_START: assert property (go_t |=> o_pread && o_stall)
    else $error("table fetch did not start");
  AST_TBL_LEN: assert property (o_pread |=> o_stall && !o_pread ##1 o_tdone && !o_stall)
    else $error("table op length wrong");
  AST_LAST_PAGE: assert property (go_t && i_treq.last_page |=> o_paddr[10:8] == 3'h7)
    else $error("last page address wrong");
  AST_RD_ANS: assert property (rd_t |=> o_rvalid)
    else $error("read not answered");
  AST_SPR_ZERO: assert property (rd_t && spr |=> o_rdata == 8'h00)
    else $error("unused location not zero");
  AST_WR_QUIET: assert property (wr_t |=> !o_rvalid)
    else $error("write answered");
  AST_BANK: assert property (wr_t && i_dreq.addr == TMM_ADDR_BANK_PTR |=>
    o_bank == $past(i_dreq.wdata[0]))
    else $error("bank not taken");
  AST_PROG_IDLE: assert property (!o_prog_serial_data_line_oe)
    else $error("programming line driven");
  cover property (o_tdone);
  cover property (go_t && i_treq.last_page);
  cover property (rd_t && i_dreq.addr[7] && o_bank);
  // Frozen cycle with a write pending
  cover property (!i_ce && i_dreq.wr);
endmodule
bind tmm_top tmm_top_monitor tmm_top_monitor_i (
  .i_clk_sys(i_clk_sys),
  .i_rstn(i_rstn),
  .i_ce(i_ce),
  .i_dreq(i_dreq),
  .o_rdata(o_rdata),
  .o_rvalid(o_rvalid),
  .i_treq(i_treq),
  .o_stall(o_stall),
  .o_tdone(o_tdone),
  .o_paddr(o_paddr),
  .o_pread(o_pread),
  .i_pdata(i_pdata),
  .i_prog_serial_data_line(i_prog_serial_data_line),
  .o_prog_serial_data_line(o_prog_serial_data_line),
  .o_prog_serial_data_line_oe(o_prog_serial_data_line_oe),
  .i_prog_serial_clock_line(i_prog_serial_clock_line),
  .o_bank(o_bank)
);
`default_nettype wire

// ---- verification/tmm_prog_mem_model.sv ----
/* Program store model.
   Assumes one word is read per i_pread pulse. */
`timescale 1ns/1ps
`default_nettype none
module tmm_prog_mem_model (
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rstn,
  // Program port
  input wire logic [10:0] i_paddr,
  input wire logic i_pread,
  output logic [15:0] o_pdata
);
  logic [10:0] a_q; // Address still answered
  logic hold_q; // Word stays one cycle past the pulse
  logic [15:0] junk_q; // Churns so stale data never matches
  function automatic logic [15:0] word(input logic [10:0] a);
    return {5'h15, a} ^ {a[7:0], 8'h5A};
  endfunction
  // Track the read so its word outlives the pulse by one cycle
  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      hold_q <= 1'b0;
      a_q <= 11'h000;
      junk_q <= 16'hA5C3;
    end else begin
      hold_q <= i_pread;
      a_q <= i_paddr;
      junk_q <= ~junk_q ^ {junk_q[14:0], 1'b1};
    end
  end
  assign o_pdata = i_pread ? word(i_paddr) : hold_q ? word(a_q) : junk_q;
endmodule
`default_nettype wire

// ---- verification/tb_tmm_top.sv ----
/* Self-checking bench for tmm_top.
   Assumes PWORD_BITS of 12, so four latch bits are unbacked. */
`timescale 1ns/1ps
`default_nettype none
module tb_tmm_top;
  import tmm_pkg::*;
  logic i_clk_sys = 1'b0;
  logic i_rstn = 1'b0;
  logic i_ce = 1'b1; // Dropped only between table reads
  tmm_dreq_t i_dreq = '0;
  tmm_treq_t i_treq = '0;
  logic [7:0] o_rdata, lo, hi, d, t;
  logic o_rvalid, o_stall, o_tdone, o_pread, o_bank, bk;
  logic [10:0] o_paddr, pa;
  logic [15:0] i_pdata, w;
  logic [7:0] mem [256]; // Expected upper halves, {bank, offset}
  int err_count = 0;
  int n_tests = 0;
  always #5 i_clk_sys = ~i_clk_sys;
  tmm_top #(.PWORD_BITS(12)) tmm_top_i (.i_clk_sys(i_clk_sys), .i_rstn(i_rstn),
    .i_ce(i_ce), .i_dreq(i_dreq), .o_rdata(o_rdata), .o_rvalid(o_rvalid),
    .i_treq(i_treq), .o_stall(o_stall), .o_tdone(o_tdone), .o_paddr(o_paddr),
    .o_pread(o_pread), .i_pdata(i_pdata), .i_prog_serial_data_line(1'b0),
    .o_prog_serial_data_line(), .o_prog_serial_data_line_oe(),
    .i_prog_serial_clock_line(1'b0), .o_bank(o_bank));
  tmm_prog_mem_model tmm_prog_mem_model_i (.i_clk_sys(i_clk_sys), .i_rstn(i_rstn),
    .i_paddr(o_paddr), .i_pread(o_pread), .o_pdata(i_pdata));
  function automatic logic [15:0] pw(input logic [10:0] a);
    return {5'h15, a} ^ {a[7:0], 8'h5A};
  endfunction
  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    n_tests++;
    if (g !== e) begin
      err_count++;
      $display("BAD t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  // Request is left up; the next call replaces it in the same step
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    i_dreq = '{rd: 1'b0, wr: 1'b1, addr: a, wdata: v};
    @(posedge i_clk_sys);
    #1;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    i_dreq = '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 8'h00};
    @(posedge i_clk_sys);
    #1;
    chk({7'h00, o_rvalid}, 8'h01);
    chk(o_rdata, e);
  endtask
  // Counts edges from the taken request to the done pulse
  task automatic tbl(input logic l, input logic [7:0] dst);
    int k;
    k = 0;
    i_dreq = '0;
    i_treq = '{go: 1'b1, last_page: l, dest: dst};
    @(posedge i_clk_sys);
    #1 i_treq = '0;
    while (k < 8 && o_tdone !== 1'b1) begin
      @(posedge i_clk_sys);
      #1;
      k++;
    end
    if (o_tdone !== 1'b1) begin
      err_count++;
      stop_test();
    end
    chk(8'(k), 8'h02);
    chk({7'h00, o_stall}, 8'h00);
    @(posedge i_clk_sys);
    #1;
    chk({7'h00, o_tdone}, 8'h00);
  endtask
  initial begin
    void'($urandom(32'h377C));
    repeat (16) @(posedge i_clk_sys);
    #1 i_rstn = 1'b1;
    // Fill both upper halves so every later read has a known value
    for (int k = 0; k < 256; k++) begin
      if (k[6:0] == 7'h00) wr(TMM_ADDR_BANK_PTR, {7'h00, k[7]});
      mem[k] = 8'($urandom);
      wr({1'b1, k[6:0]}, mem[k]);
    end
    for (int k = 0; k < 300; k++) begin
      t = 8'($urandom);
      d = 8'h80 | 8'($urandom);
      bk = t[0];
      wr(TMM_ADDR_BANK_PTR, t);
      chk({7'h00, o_bank}, {7'h00, bk});
      if (t[1]) mem[{bk, d[6:0]}] = t ^ d;
      if (t[1]) wr(d, t ^ d);
      else rd(d, mem[{bk, d[6:0]}]);
      // Enable low for one edge: the pending write must leave no trace
      i_ce = 1'b0;
      wr(d, ~mem[{bk, d[6:0]}]);
      i_ce = 1'b1;
      rd(d, mem[{bk, d[6:0]}]);
      wr({2'b01, d[5:0]}, t);
      rd({2'b01, d[5:0]}, 8'h00);
    end
    for (int k = 0; k < 40; k++) begin
      lo = (k < 2) ? {8{k[0]}} : 8'($urandom);
      hi = (k < 2) ? {8{k[0]}} : 8'($urandom);
      t = 8'($urandom);
      bk = t[1];
      wr(TMM_ADDR_BANK_PTR, {7'h00, bk});
      wr(TMM_ADDR_LOW_PTR, lo);
      wr(TMM_ADDR_HIGH_PTR, hi);
      pa = t[0] ? {3'h7, lo} : {hi[2:0], lo};
      w = pw(pa);
      d = 8'h80 | t;
      // No second table read before the latch is read back, as software must
      tbl(t[0], d);
      mem[{bk, d[6:0]}] = w[7:0];
      rd(d, w[7:0]);
      wr(TMM_ADDR_HIGH_BYTE, ~w[15:8]);
      rd(TMM_ADDR_HIGH_BYTE, w[15:8] & 8'h0F);
    end
    stop_test();
  end
endmodule
`default_nettype wire
